// ### rtl/ascp_pkg.sv
package ascp_pkg;
  localparam logic [7:0] ADDR_PORT_CFG   = 8'h00;
  localparam logic [7:0] ADDR_CHIP_ID    = 8'h01;
  localparam logic [7:0] ADDR_CHIP_GRADE = 8'h02;
  localparam logic [7:0] ADDR_INDEX      = 8'h05;
  localparam logic [7:0] ADDR_MODES      = 8'h08;
  localparam logic [7:0] ADDR_CLOCK      = 8'h09;
  localparam logic [7:0] ADDR_FUNC_LAST  = 8'h22;
  localparam logic [7:0] ADDR_TRANSFER   = 8'hff;
  localparam logic [7:0] RST_PORT_CFG    = 8'h18;
  localparam logic [7:0] RST_INDEX       = 8'h0f;
  localparam logic [7:0] RST_MODES       = 8'h00;
  localparam logic [7:0] RST_CLOCK       = 8'h01;
  localparam logic [7:0] RST_FUNC        = 8'h00;
  localparam logic [7:0] XFER_VALUE      = 8'h01;
  localparam logic [7:0] PCFG_FIXED_ONES = 8'h18;
  localparam int         PCFG_LSB_HI     = 6;
  localparam int         PCFG_LSB_LO     = 1;
  localparam int         PCFG_SRST_HI    = 5;
  localparam int         PCFG_SRST_LO    = 2;
  localparam int         CLOCK_DCS_BIT   = 0;
  localparam int         INSTR_BITS      = 16;
  localparam logic [7:0] CHIP_ID_VALUE   = 8'h5a; // arbitrary value
  localparam logic [7:0] CHIP_GRADE_VALUE = 8'h30; // arbitrary value
  typedef enum logic [1:0] {
    ASCP_IDLE  = 2'b00,
    ASCP_INSTR = 2'b01,
    ASCP_DATA  = 2'b10
  } ascp_state_t;
endpackage : ascp_pkg

// ### rtl/ascp_sync.sv
`timescale 1ns/10ps
module ascp_sync (
  input  wire logic mclk_i,   // system clock
  input  wire logic resetn_i, // sync reset, active low
  input  wire logic async_i,  // pin level
  output logic      sync_o    // synchronised level
);
  logic meta;

  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      meta   <= 1'b1;
      sync_o <= 1'b1;
    end
    else
    begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule : ascp_sync

// ### rtl/ascp_top.sv
// Functional notes
// - data pin is input during writes, driven only while returning read data
// - serial clock and chip select are inputs only, never driven
// - chip select high at power-up disables port; pins become strap inputs
// - writing 0x01 to 0xff copies shadow registers into active registers
// - reset loads every register with its default value
// - decode 0x00-0x02, 0x05 and 0xff, and 0x08-0x22
// - port config resets 0x18, mirrored order and soft-reset bits, fixed bits
// - clock register resets 0x01; stabiliser off only after clear plus transfer
// - frame starts at chip select low; 16-bit instruction; word length 1-3 or stream
// - chip select high mid-byte resets engine; streaming runs until chip select rises
// - msb first after reset, lsb first only when port config says so
`timescale 1ns/10ps
module ascp_top (
  input  wire logic        mclk_i,                        // 200 MHz clock
  input  wire logic        resetn_i,                      // sync reset, active low
  input  wire logic        chip_select_n_i,               // serial chip select pin
  input  wire logic        serial_clock_or_test_pattern_strap_i, // serial clock pin
  input  wire logic        serial_data_or_output_mode_strap_i,   // data pin input
  output logic             serial_data_or_output_mode_strap_o,   // data pin output
  output logic             serial_data_oe_n_o,            // data pin enable, low drives
  output logic             strap_mode_o,                  // port disabled, straps active
  output logic             test_pattern_strap_o,          // strap level of clock pin
  output logic             output_mode_strap_o,           // strap level of data pin
  output logic [7:0]       active_modes_o,                // active power mode register
  output logic             duty_cycle_stabilizer_o,       // active stabiliser enable
  output logic [7:0]       active_index_o                 // active channel index
);
  logic                    cs_n, sck, sdi, sck_q;
  logic [1:0]              strap_wait;
  logic                    rise, fall;
  ascp_pkg::ascp_state_t   state;
  logic [4:0]              bit_cnt;
  logic [15:0]             shift_in;
  logic                    rd, lsb_first, soft_reset;
  logic [1:0]              wlen;
  logic [7:0]              addr, byte_cnt, tx;
  logic [7:0]              shadow [8:34];
  logic [7:0]              active [8:34];
  logic [7:0]              shadow_index;
  logic                    byte_done, instr_done;

  // chip select and clock only ever sampled, never driven; data input sampled here, driven only for reads
  ascp_sync u_cs (.mclk_i(mclk_i), .resetn_i(resetn_i), .async_i(chip_select_n_i),
                  .sync_o(cs_n));
  ascp_sync u_ck (.mclk_i(mclk_i), .resetn_i(resetn_i),
                  .async_i(serial_clock_or_test_pattern_strap_i), .sync_o(sck));
  ascp_sync u_di (.mclk_i(mclk_i), .resetn_i(resetn_i),
                  .async_i(serial_data_or_output_mode_strap_i), .sync_o(sdi));

  function automatic logic in_map(input logic [7:0] a);
    in_map = (a <= ascp_pkg::ADDR_CHIP_GRADE) || (a == ascp_pkg::ADDR_INDEX) ||
             (a >= ascp_pkg::ADDR_MODES && a <= ascp_pkg::ADDR_FUNC_LAST) ||
             (a == ascp_pkg::ADDR_TRANSFER);
  endfunction : in_map

  function automatic logic [7:0] reset_value(input logic [7:0] a);
    if (a == ascp_pkg::ADDR_CLOCK)
      reset_value = ascp_pkg::RST_CLOCK;
    else if (a == ascp_pkg::ADDR_MODES)
      reset_value = ascp_pkg::RST_MODES;
    else
      reset_value = ascp_pkg::RST_FUNC;
  endfunction : reset_value

  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
      sck_q <= 1'b0;
    else
      sck_q <= sck;
  end
  assign rise = sck && !sck_q && !cs_n && !strap_mode_o;
  assign fall = !sck && sck_q && !cs_n && !strap_mode_o;

  // strap mode sampled once after reset release and held until reset; strap levels follow the pins only in strap mode
  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      strap_wait           <= 2'd0;
      strap_mode_o         <= 1'b0;
      test_pattern_strap_o <= 1'b0;
      output_mode_strap_o  <= 1'b0;
    end
    else
    begin
      // the synchroniser shows its reset level for two edges; look past it
      if (strap_wait != 2'd3)
        strap_wait <= strap_wait + 2'd1;
      if (strap_wait == 2'd2)
        strap_mode_o <= cs_n;
      if (strap_mode_o)
      begin
        test_pattern_strap_o <= sck;
        output_mode_strap_o  <= sdi;
      end
    end
  end

  assign byte_done  = rise && (state == ascp_pkg::ASCP_DATA) && (bit_cnt == 5'd7);
  assign instr_done = rise && (state == ascp_pkg::ASCP_INSTR) &&
                      (bit_cnt == 5'(ascp_pkg::INSTR_BITS - 1));

  logic [15:0] next_instr;
  logic        bit_in;
  assign next_instr = {shift_in[14:0], sdi};
  assign bit_in     = sdi;

  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i || cs_n || strap_mode_o)
    begin
      state    <= ascp_pkg::ASCP_IDLE;
      bit_cnt  <= 5'd0;
      shift_in <= 16'h0000;
      rd       <= 1'b0;
      wlen     <= 2'b00;
      addr     <= 8'h00;
      byte_cnt <= 8'h00;
    end
    else if (rise)
    begin
      unique case (state)
        ascp_pkg::ASCP_IDLE, ascp_pkg::ASCP_INSTR:
        begin
          state    <= ascp_pkg::ASCP_INSTR;
          shift_in <= next_instr;
          bit_cnt  <= instr_done ? 5'd0 : bit_cnt + 5'd1;
          if (instr_done)
          begin
            state <= ascp_pkg::ASCP_DATA;
            rd    <= next_instr[15];
            wlen  <= next_instr[14:13]; // word_length_bit1, word_length_bit0
            addr  <= next_instr[7:0];
          end
        end
        ascp_pkg::ASCP_DATA:
        begin
          // order follows port config: msb first by default
          shift_in <= lsb_first ? {8'h00, bit_in, shift_in[7:1]}
                                : {8'h00, shift_in[6:0], bit_in};
          bit_cnt  <= byte_done ? 5'd0 : bit_cnt + 5'd1;
          if (byte_done)
          begin
            byte_cnt <= byte_cnt + 8'd1;
            addr     <= lsb_first ? addr + 8'd1 : addr - 8'd1;
            // word length 11 streams until chip select rises
            if (wlen != 2'b11 && byte_cnt == {6'h00, wlen})
              state <= ascp_pkg::ASCP_IDLE;
          end
        end
        default:
          state <= ascp_pkg::ASCP_IDLE;
      endcase
    end
  end

  logic [7:0] wbyte;
  assign wbyte = lsb_first ? {bit_in, shift_in[7:1]} : {shift_in[6:0], bit_in};
  logic wr_stb;
  assign wr_stb = byte_done && !rd && in_map(addr);

  // port config: mirrored order and soft-reset bits, fixed ones and zeros
  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i || soft_reset)
    begin
      lsb_first  <= 1'b0;
      soft_reset <= 1'b0;
    end
    else if (wr_stb && addr == ascp_pkg::ADDR_PORT_CFG)
    begin
      lsb_first  <= wbyte[ascp_pkg::PCFG_LSB_HI] | wbyte[ascp_pkg::PCFG_LSB_LO];
      soft_reset <= wbyte[ascp_pkg::PCFG_SRST_HI] | wbyte[ascp_pkg::PCFG_SRST_LO];
    end
  end

  logic xfer;
  assign xfer = wr_stb && addr == ascp_pkg::ADDR_TRANSFER && wbyte == ascp_pkg::XFER_VALUE;

  // shadow and active banks; transfer copies shadow to active
  genvar g;
  generate
    for (g = 8; g <= 34; g++)
    begin : g_reg
      always_ff @(posedge mclk_i)
      begin
        if (!resetn_i || soft_reset)
        begin
          shadow[g] <= reset_value(8'(g));
          active[g] <= reset_value(8'(g));
        end
        else
        begin
          if (wr_stb && addr == 8'(g))
            shadow[g] <= wbyte;
          if (xfer)
            active[g] <= shadow[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i || soft_reset)
    begin
      shadow_index   <= ascp_pkg::RST_INDEX;
      active_index_o <= ascp_pkg::RST_INDEX;
    end
    else
    begin
      if (wr_stb && addr == ascp_pkg::ADDR_INDEX)
        shadow_index <= wbyte;
      if (xfer)
        active_index_o <= shadow_index;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i || soft_reset)
    begin
      active_modes_o          <= ascp_pkg::RST_MODES;
      duty_cycle_stabilizer_o <= ascp_pkg::RST_CLOCK[ascp_pkg::CLOCK_DCS_BIT];
    end
    else
    begin
      active_modes_o          <= active[ascp_pkg::ADDR_MODES];
      duty_cycle_stabilizer_o <= active[ascp_pkg::ADDR_CLOCK][ascp_pkg::CLOCK_DCS_BIT];
    end
  end

  function automatic logic [7:0] read_reg(input logic [7:0] a);
    if (a == ascp_pkg::ADDR_PORT_CFG)
      read_reg = ascp_pkg::PCFG_FIXED_ONES | {1'b0, lsb_first, 4'h0, lsb_first, 1'b0};
    else if (a == ascp_pkg::ADDR_CHIP_ID)
      read_reg = ascp_pkg::CHIP_ID_VALUE;
    else if (a == ascp_pkg::ADDR_CHIP_GRADE)
      read_reg = ascp_pkg::CHIP_GRADE_VALUE;
    else if (a == ascp_pkg::ADDR_INDEX)
      read_reg = shadow_index;
    else if (a >= ascp_pkg::ADDR_MODES && a <= ascp_pkg::ADDR_FUNC_LAST)
      read_reg = shadow[a];
    else
      read_reg = 8'h00;
  endfunction : read_reg

  logic [7:0] rdata;
  assign rdata = read_reg(addr);

  // read data changes on the falling clock edge, sampled by the host on the rise
  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i || cs_n || strap_mode_o)
    begin
      tx                                 <= 8'h00;
      serial_data_or_output_mode_strap_o <= 1'b0;
      serial_data_oe_n_o                 <= 1'b1;
    end
    else if (fall && rd && state == ascp_pkg::ASCP_DATA)
    begin
      serial_data_oe_n_o <= 1'b0;
      if (bit_cnt == 5'd0)
      begin
        tx <= lsb_first ? rdata >> 1 : rdata << 1;
        serial_data_or_output_mode_strap_o <= lsb_first ? rdata[0] : rdata[7];
      end
      else
      begin
        tx <= lsb_first ? tx >> 1 : tx << 1;
        serial_data_or_output_mode_strap_o <= lsb_first ? tx[0] : tx[7];
      end
    end
    else if (state != ascp_pkg::ASCP_DATA || !rd)
      serial_data_oe_n_o <= 1'b1;
  end
endmodule : ascp_top

// ### test/ascp_chk.sv
`timescale 1ns/10ps
module ascp_chk (
  input  wire logic       mclk_i,                               // clock
  input  wire logic       resetn_i,                             // reset, low active
  input  wire logic       chip_select_n_i,                      // select pin
  input  wire logic       serial_clock_or_test_pattern_strap_i, // clock pin
  input  wire logic       serial_data_or_output_mode_strap_i,   // data pin in
  input  wire logic       serial_data_or_output_mode_strap_o,   // data pin out
  input  wire logic       serial_data_oe_n_o,                   // data enable
  input  wire logic       strap_mode_o,                         // strap mode
  input  wire logic       test_pattern_strap_o,                 // clock strap
  input  wire logic       output_mode_strap_o,                  // data strap
  input  wire logic [7:0] active_modes_o,                       // modes
  input  wire logic       duty_cycle_stabilizer_o,              // stabiliser
  input  wire logic [7:0] active_index_o                        // index
);
  wire cs  = chip_select_n_i;
  wire sck = serial_clock_or_test_pattern_strap_i;
  wire oen = serial_data_oe_n_o;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  a_oe_idle_release: assert property (cs [*8] |-> oen)
    else $error("data pin driven while deselected");
  a_drive_on_fall: assert property ($fell(oen) |-> !sck && !cs)
    else $error("data pin enabled outside low clock phase");
  a_data_held: assert property (!oen && !$past(oen)
    && $changed(serial_data_or_output_mode_strap_o) |-> !sck)
    else $error("read data moved while clock high");
  a_reset_defaults: assert property (disable iff (1'b0) !resetn_i |=> oen
    && active_modes_o == 8'h00 && duty_cycle_stabilizer_o && active_index_o == 8'h0f)
    else $error("reset values wrong");
  a_strap_quiet: assert property (strap_mode_o |-> oen)
    else $error("data pin driven in strap mode");
  a_strap_clock: assert property ((strap_mode_o && $stable(sck)) [*6]
    |-> test_pattern_strap_o == sck)
    else $error("clock strap level wrong");
  a_strap_data: assert property ((strap_mode_o
    && $stable(serial_data_or_output_mode_strap_i)) [*6]
    |-> output_mode_strap_o == serial_data_or_output_mode_strap_i)
    else $error("data strap level wrong");
  a_abort_release: assert property ($rose(cs) |-> ##[1:6] oen)
    else $error("data pin kept after deselect");
  a_commit_in_frame: assert property (($changed(active_modes_o)
    || $changed(duty_cycle_stabilizer_o) || $changed(active_index_o)) |-> !cs)
    else $error("active value changed outside a frame");
endmodule : ascp_chk
bind ascp_top ascp_chk ascp_chk_inst (.*);

// ### test/ascp_ctrl.sv
`timescale 1ns/10ps
module ascp_ctrl (
  input  wire logic mclk_i,     // bench clock
  input  wire logic dev_d_i,    // device data out
  input  wire logic dev_oe_n_i, // device enable, low drives
  output logic      cs_n_o,     // chip select
  output logic      sck_o,      // serial clock, still between frames
  output logic      pin_o       // resolved data pin
);
  logic ctl_en = 1'b0;
  logic ctl_d  = 1'b0;
  logic last   = 1'b0;
  int   clash  = 0;
  initial cs_n_o = 1'b0;
  initial sck_o = 1'b0;
  // nobody driving: show the inverse of the last level so a stale value never passes
  assign pin_o = !dev_oe_n_i ? dev_d_i : (ctl_en ? ctl_d : ~last);
  always @(posedge mclk_i)
  begin
    // remember only driven levels, so a released pin holds one steady wrong level
    if (ctl_en || !dev_oe_n_i)
      last <= pin_o;
    if (ctl_en && !dev_oe_n_i)
      clash++;
  end
  task automatic sbit(input logic d, input logic drv, output logic q);
    sck_o  <= 1'b0;
    ctl_d  <= d;
    ctl_en <= drv;
    repeat (16) @(posedge mclk_i);
    sck_o <= 1'b1;
    q = pin_o;
    repeat (16) @(posedge mclk_i);
  endtask : sbit
  // nbit below 8 per byte and not a multiple of 8 cuts the frame short in mid-byte
  task automatic frame(input logic rd, input logic [1:0] wl, input logic [7:0] ad,
                       input logic [31:0] wd, input int nbit, input logic lsb,
                       output logic [31:0] rv);
    logic [15:0] ins;
    logic        q;
    int          j;
    ins = {rd, wl, 5'h00, ad};
    rv = 32'h0;
    cs_n_o <= 1'b0;
    repeat (16) @(posedge mclk_i);
    for (int i = 15; i >= 0; i--)
      sbit(ins[i], 1'b1, q);
    for (int k = 0; k < nbit; k++)
    begin
      j = (k / 8) * 8 + (lsb ? k % 8 : 7 - k % 8);
      sbit(wd[j], !rd, q);
      rv[j] = q;
    end
    sck_o  <= 1'b0;
    ctl_en <= 1'b0;
    repeat (16) @(posedge mclk_i);
    cs_n_o <= 1'b1;
    repeat (16) @(posedge mclk_i);
  endtask : frame
  task automatic pins(input logic c, input logic k, input logic d, input logic e);
    cs_n_o <= c;
    sck_o  <= k;
    ctl_d  <= d;
    ctl_en <= e;
    @(posedge mclk_i);
  endtask : pins
endmodule : ascp_ctrl

// ### test/tb.sv
`timescale 1ns/10ps
module tb;
  logic        mclk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        chip_select_n_i, serial_clock_or_test_pattern_strap_i;
  logic        serial_data_or_output_mode_strap_i, serial_data_or_output_mode_strap_o;
  logic        serial_data_oe_n_o, strap_mode_o, test_pattern_strap_o, output_mode_strap_o;
  logic [7:0]  active_modes_o, active_index_o;
  logic        duty_cycle_stabilizer_o;
  logic [31:0] rv;
  logic [7:0]  seed = 8'h42;
  logic [7:0]  exp_m = 8'h00;
  logic [7:0]  exp_i = 8'h0f;
  logic        lsb = 1'b0;
  logic [7:0]  ads [8] = '{8'h00, 8'h05, 8'h09, 8'h08, 8'h03, 8'h23, 8'h30, 8'hfe};
  logic [7:0]  dfl [8] = '{8'h18, 8'h0f, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  int          errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  always #2.5 mclk_i = ~mclk_i;
  ascp_top ascp_top_inst (.*);
  ascp_ctrl ascp_ctrl_inst (.mclk_i, .dev_d_i(serial_data_or_output_mode_strap_o),
    .dev_oe_n_i(serial_data_oe_n_o), .cs_n_o(chip_select_n_i),
    .sck_o(serial_clock_or_test_pattern_strap_i), .pin_o(serial_data_or_output_mode_strap_i));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic [7:0] pcfg(input logic [7:0] w);
    return (w & 8'h66) | 8'h18;
  endfunction : pcfg
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ascp_ctrl_inst.frame(1'b0, 2'b00, a, {24'h0, d}, 8, lsb, rv);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    ascp_ctrl_inst.frame(1'b1, 2'b00, a, 32'h0, 8, lsb, rv);
  endtask : rd
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      errors++;
      conclude();
    end
  end
  initial
  begin
    repeat (6) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    ascp_ctrl_inst.pins(1'b1, 1'b0, 1'b0, 1'b0);
    repeat (8) @(posedge mclk_i);
    chk("modes", 8'h00, active_modes_o);
    chk("dcs", 8'h01, {7'h0, duty_cycle_stabilizer_o});
    chk("index", 8'h0f, active_index_o);
    chk("strap", 8'h00, {7'h0, strap_mode_o});
    for (int i = 0; i < 8; i++)
    begin
      rd(ads[i]);
      chk("default", dfl[i], rv[7:0]);
    end
    for (int n = 0; n < 3; n++)
    begin
      seed = lfsr(seed);
      wr(8'h08, seed & 8'h07);
      chk("hold", exp_m, active_modes_o);
      wr(8'h05, {2'b00, seed[5:0]});
      chk("hold_idx", exp_i, active_index_o);
      rd(8'h08);
      chk("shadow", seed & 8'h07, rv[7:0]);
      wr(8'hff, 8'h01);
      exp_m = seed & 8'h07;
      exp_i = {2'b00, seed[5:0]};
      chk("commit", exp_m, active_modes_o);
      chk("commit_idx", exp_i, active_index_o);
    end
    wr(8'h09, 8'h00);
    chk("dcs", 8'h01, {7'h0, duty_cycle_stabilizer_o});
    wr(8'hff, 8'h01);
    chk("dcs", 8'h00, {7'h0, duty_cycle_stabilizer_o});
    ascp_ctrl_inst.frame(1'b0, 2'b00, 8'h08, 32'h7, 4, lsb, rv);
    wr(8'hff, 8'h01);
    chk("abort", exp_m, active_modes_o);
    ascp_ctrl_inst.frame(1'b0, 2'b01, 8'h09, 32'h0501, 16, lsb, rv);
    ascp_ctrl_inst.frame(1'b1, 2'b10, 8'h0a, 32'h0, 24, lsb, rv);
    chk("burst0", 8'h00, rv[7:0]);
    chk("burst1", 8'h01, rv[15:8]);
    chk("burst2", 8'h05, rv[23:16]);
    ascp_ctrl_inst.frame(1'b1, 2'b11, 8'h09, 32'h0, 24, lsb, rv);
    chk("stream0", 8'h01, rv[7:0]);
    chk("stream1", 8'h05, rv[15:8]);
    chk("stream2", 8'h00, rv[23:16]);
    wr(8'hff, 8'h01);
    chk("modes", 8'h05, active_modes_o);
    wr(8'h00, 8'h42);
    lsb = 1'b1;
    rd(8'h00);
    chk("order", pcfg(8'h42), rv[7:0]);
    wr(8'h00, 8'h24);
    lsb = 1'b0;
    rd(8'h00);
    chk("softrst", 8'h18, rv[7:0]);
    chk("softrst", 8'h00, active_modes_o);
    chk("softrst", 8'h0f, active_index_o);
    resetn_i <= 1'b0;
    ascp_ctrl_inst.pins(1'b1, 1'b1, 1'b1, 1'b1);
    repeat (4) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    chk("strap", 8'h01, {7'h0, strap_mode_o});
    chk("tp", 8'h01, {7'h0, test_pattern_strap_o});
    chk("om", 8'h01, {7'h0, output_mode_strap_o});
    ascp_ctrl_inst.pins(1'b1, 1'b0, 1'b0, 1'b1);
    repeat (10) @(posedge mclk_i);
    chk("tp", 8'h00, {7'h0, test_pattern_strap_o});
    chk("om", 8'h00, {7'h0, output_mode_strap_o});
    chk("clash", 8'h00, 8'(ascp_ctrl_inst.clash));
    conclude();
  end
endmodule : tb
